// file: logic/clock_cfg_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "clock_cfg_map.svh"
module clock_cfg_ctrl #(
	parameter int POR_CYCLES = `POR_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
	parameter int CYC_PER_MS = `NS_PER_MS / `CLK_PERIOD_NS
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic supply_ok,
	input wire clock_cfg_pkg::reg_req_s host_req,
	output logic [7:0] host_rdata,
	output logic host_rvalid,
	input wire logic strap_pin_0,
	input wire logic strap_pin_1,
	input wire logic interface_select_strap,
	input wire logic strap_pin_4,
	input wire logic strap_pin_5,
	input wire logic serial_data_out_data,
	input wire logic serial_data_out_en,
	output logic strap_pin_4_o,
	output logic strap_pin_4_oe,
	output logic mpin4_free,
	output logic mpin5_free,
	output clock_cfg_pkg::strap_s strap_latched,
	output logic profile_load,
	output logic device_in_reset,
	input wire logic [71:0] irq_event,
	output logic [2:0] irq_pin_o,
	output logic [2:0] irq_pin_oe,
	output logic wdog_pin_o,
	output logic wdog_pin_oe,
	input wire logic system_clock_pll_locked,
	output logic system_clock_stable,
	output logic [1:0] free_run,
	output logic [1:0] soft_sync,
	output logic [1:0] cal_start,
	output logic [29:0] free_run_word_0,
	output logic [29:0] free_run_word_1,
	output logic [7:0] driver_enable_0,
	output logic [7:0] driver_enable_1,
	input wire logic [1:0] loop0_ref_sel,
	input wire logic [1:0] loop1_ref_sel,
	output logic [7:0] loop0_priority,
	output logic [7:0] loop1_priority,
	output logic [7:0] ref_settings_first [4]
);
	localparam int WD_PULSE_RAW = (`WD_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam logic [3:0] WD_PULSE_CYC = 4'((WD_PULSE_RAW < 1) ? 1 : WD_PULSE_RAW);

	// Returns {hit, index} into the buffered store
	function automatic logic [9:0] map_addr(input logic [15:0] a);
		logic [7:0] region;
		region = a[15:8] - `REGION_REF;
		map_addr = 10'h000;
		if (a[15:8] >= `REGION_REF && a[15:8] <= `REGION_LOOP1 && !a[7]) begin
			map_addr = {1'b1, region[1:0], a[6:0]};
		end else if (a >= `ADDR_MASK_FIRST && a <= `ADDR_MASK_LAST) begin
			map_addr = {1'b1, 9'(`IX_MASK + 9'(a - `ADDR_MASK_FIRST))};
		end else begin
			case (a)
				`ADDR_SERIAL_CFG: map_addr = {1'b1, `IX_SPCFG};
				`ADDR_MPIN_CFG: map_addr = {1'b1, `IX_MPIN};
				`ADDR_WDOG_LO: map_addr = {1'b1, `IX_WD_LO};
				`ADDR_WDOG_HI: map_addr = {1'b1, `IX_WD_HI};
				`ADDR_STAB_LO: map_addr = {1'b1, `IX_STAB_LO};
				`ADDR_STAB_HI: map_addr = {1'b1, `IX_STAB_HI};
				`ADDR_PLL0_CAL: map_addr = {1'b1, `IX_PLL0_CAL};
				`ADDR_LOOP0_FR: map_addr = {1'b1, `IX_LOOP0_FR};
				`ADDR_PLL1_CAL: map_addr = {1'b1, `IX_PLL1_CAL};
				`ADDR_LOOP1_FR: map_addr = {1'b1, `IX_LOOP1_FR};
				default: map_addr = 10'h000;
			endcase
		end
	endfunction

	logic [31:0] por_cnt_r, por_cnt_nxt;
	logic por_busy, dev_rst;
	clock_cfg_pkg::boot_state_e boot_r, boot_nxt;
	clock_cfg_pkg::strap_s strap_r, strap_nxt;
	logic [7:0] shadow_r [`IX_COUNT];
	logic [7:0] active_r [`IX_COUNT];
	logic [9:0] map;
	logic wr_hit, upd, clr_all, wd_clr;
	logic [7:0] mon_r [`GROUP_COUNT];
	logic [7:0] mon_nxt [`GROUP_COUNT];
	logic [2:0] grp;
	logic [15:0] wd_ms, stab_ms;
	logic [31:0] wd_pre_r, wd_pre_nxt, st_pre_r, st_pre_nxt;
	logic [15:0] wd_cnt_r, wd_cnt_nxt, st_cnt_r, st_cnt_nxt;
	logic wd_expire, stable_r, stable_nxt;
	logic [3:0] wd_pulse_r, wd_pulse_nxt;
	logic [7:0] snap_r, snap_nxt, rdata_nxt;
	logic [1:0] cal_prev_r, cal_prev_nxt, cal_start_r, cal_start_nxt, cal_act;
	logic [2:0] irq_o_r, irq_o_nxt, irq_oe_r, irq_oe_nxt;
	logic rvalid_nxt;
	logic [6:0] prof0, prof1;

	// Power-on pulse runs off the supply monitor only, not the pin
	always_comb begin
		por_cnt_nxt = por_cnt_r;
		if (!supply_ok) begin
			por_cnt_nxt = 32'h0000_0000;
		end else if (por_busy) begin
			por_cnt_nxt = por_cnt_r + 32'h0000_0001;
		end
	end
	assign por_busy = por_cnt_r != 32'(POR_CYCLES);
	assign dev_rst = !reset_n || por_busy;

	// Straps caught two clocks after reset clears, never by the reset itself
	always_comb begin
		boot_nxt = boot_r;
		strap_nxt = strap_r;
		case (boot_r)
			clock_cfg_pkg::BOOT_HOLD: boot_nxt = clock_cfg_pkg::BOOT_LATCH;
			clock_cfg_pkg::BOOT_LATCH: begin
				strap_nxt.profile = {strap_pin_1, strap_pin_0};
				strap_nxt.i2c_mode = interface_select_strap;
				strap_nxt.i2c_addr = {strap_pin_5, strap_pin_4};
				boot_nxt = clock_cfg_pkg::BOOT_RUN;
			end
			clock_cfg_pkg::BOOT_RUN: boot_nxt = clock_cfg_pkg::BOOT_RUN;
			default: boot_nxt = clock_cfg_pkg::BOOT_HOLD;
		endcase
	end

	assign map = map_addr(host_req.addr);
	assign wr_hit = host_req.wr && map[9] && boot_r == clock_cfg_pkg::BOOT_RUN;
	assign upd = host_req.wr && host_req.addr == `ADDR_UPDATE && host_req.wdata == `UPDATE_CMD;
	assign clr_all = host_req.wr && host_req.addr == `ADDR_CLR_COMMON && host_req.wdata[`CLR_ALL_BIT];
	assign wd_clr = host_req.wr && host_req.addr == `ADDR_CLR_COMMON && host_req.wdata[`CLR_WDOG_BIT];

	// Writes land in shadow; active changes only on the update command
	always_ff @(posedge core_clk) begin
		if (dev_rst) begin
			for (int i = 0; i < `IX_COUNT; i++) begin
				shadow_r[i] <= 8'h00;
				active_r[i] <= 8'h00;
			end
			shadow_r[`IX_STAB_LO] <= `STAB_DEFAULT_MS;
			active_r[`IX_STAB_LO] <= `STAB_DEFAULT_MS;
		end else begin
			if (wr_hit) begin
				shadow_r[map[8:0]] <= host_req.wdata;
			end
			if (upd) begin
				for (int i = 0; i < `IX_COUNT; i++) begin
					active_r[i] <= shadow_r[i];
				end
			end
		end
	end

	// Set beats clear when both land in one cycle
	genvar g;
	generate
		for (g = 0; g < `GROUP_COUNT; g++) begin : g_mon
			logic [7:0] set_bits, clr_bits;
			always_comb begin
				set_bits = irq_event[g*8 +: 8] & active_r[`IX_MASK + g];
				if (g == 0) begin
					set_bits[0] = set_bits[0] | (wd_expire && active_r[`IX_MASK][0]);
				end
				clr_bits = 8'h00;
				if (host_req.wr && host_req.addr == 16'(`ADDR_CLR_FIRST + g)) begin
					clr_bits = host_req.wdata;
				end
				if (clr_all) begin
					clr_bits = 8'hFF;
				end
				mon_nxt[g] = (mon_r[g] & ~clr_bits) | set_bits;
			end
		end
	endgenerate

	assign grp[0] = |{mon_r[0], mon_r[1], mon_r[2]};
	assign grp[1] = |{mon_r[3], mon_r[4], mon_r[5]};
	assign grp[2] = |{mon_r[6], mon_r[7], mon_r[8]};
	assign wd_ms = {active_r[`IX_WD_HI], active_r[`IX_WD_LO]};
	assign stab_ms = {active_r[`IX_STAB_HI], active_r[`IX_STAB_LO]};
	assign cal_act = {active_r[`IX_PLL1_CAL][`CAL_BIT], active_r[`IX_PLL0_CAL][`CAL_BIT]};
	assign wd_expire = wd_ms != 16'h0000 && wd_pre_r == 32'(CYC_PER_MS - 1) && wd_cnt_r + 16'h0001 >= wd_ms;

	always_comb begin
		wd_pre_nxt = wd_pre_r + 32'h0000_0001;
		wd_cnt_nxt = wd_cnt_r;
		if (wd_ms == 16'h0000 || wd_clr) begin
			wd_pre_nxt = 32'h0000_0000;
			wd_cnt_nxt = 16'h0000;
		end else if (wd_pre_r == 32'(CYC_PER_MS - 1)) begin
			wd_pre_nxt = 32'h0000_0000;
			wd_cnt_nxt = wd_expire ? 16'h0000 : wd_cnt_r + 16'h0001;
		end
		wd_pulse_nxt = wd_pulse_r == 4'h0 ? 4'h0 : wd_pulse_r - 4'h1;
		if (wd_expire) begin
			wd_pulse_nxt = WD_PULSE_CYC;
		end
		// Stability clock restarts on any loss of lock
		st_pre_nxt = st_pre_r;
		st_cnt_nxt = st_cnt_r;
		stable_nxt = stable_r;
		if (!system_clock_pll_locked) begin
			st_pre_nxt = 32'h0000_0000;
			st_cnt_nxt = 16'h0000;
			stable_nxt = 1'b0;
		end else if (st_cnt_r >= stab_ms) begin
			stable_nxt = 1'b1;
		end else if (st_pre_r == 32'(CYC_PER_MS - 1)) begin
			st_pre_nxt = 32'h0000_0000;
			st_cnt_nxt = st_cnt_r + 16'h0001;
		end else begin
			st_pre_nxt = st_pre_r + 32'h0000_0001;
		end
		snap_nxt = upd ? {6'h00, stable_r, system_clock_pll_locked} : snap_r;
		cal_prev_nxt = cal_act;
		cal_start_nxt = cal_act & ~cal_prev_r;
		irq_o_nxt = 3'h0;
		irq_oe_nxt = 3'h0;
		for (int k = 0; k < 3; k++) begin
			logic act;
			act = active_r[`IX_MPIN][`MPIN_SINGLE_IRQ_BIT] ? (k == 0 && |grp) : grp[k];
			if (active_r[`IX_MPIN][`MPIN_PUSH_PULL_BIT]) begin
				irq_o_nxt[k] = act;
				irq_oe_nxt[k] = 1'b1;
			end else begin
				irq_oe_nxt[k] = act;
			end
		end
		rvalid_nxt = host_req.rd;
		rdata_nxt = 8'h00;
		if (host_req.rd) begin
			if (map[9]) begin
				rdata_nxt = shadow_r[map[8:0]];
			end else if (host_req.addr == `ADDR_SYS_STATUS) begin
				rdata_nxt = snap_r;
			end else if (host_req.addr >= `ADDR_MON_FIRST && host_req.addr <= `ADDR_MON_LAST) begin
				rdata_nxt = mon_r[4'(host_req.addr - `ADDR_MON_FIRST)];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		por_cnt_r <= por_cnt_nxt;
		if (dev_rst) begin
			boot_r <= clock_cfg_pkg::BOOT_HOLD;
			strap_r <= '0;
			for (int i = 0; i < `GROUP_COUNT; i++) begin
				mon_r[i] <= 8'h00;
			end
			wd_pre_r <= 32'h0000_0000;
			wd_cnt_r <= 16'h0000;
			wd_pulse_r <= 4'h0;
			st_pre_r <= 32'h0000_0000;
			st_cnt_r <= 16'h0000;
			stable_r <= 1'b0;
			snap_r <= 8'h00;
			cal_prev_r <= 2'h0;
			cal_start_r <= 2'h0;
			irq_o_r <= 3'h0;
			irq_oe_r <= 3'h0;
			host_rdata <= 8'h00;
			host_rvalid <= 1'b0;
		end else begin
			boot_r <= boot_nxt;
			strap_r <= strap_nxt;
			for (int i = 0; i < `GROUP_COUNT; i++) begin
				mon_r[i] <= mon_nxt[i];
			end
			wd_pre_r <= wd_pre_nxt;
			wd_cnt_r <= wd_cnt_nxt;
			wd_pulse_r <= wd_pulse_nxt;
			st_pre_r <= st_pre_nxt;
			st_cnt_r <= st_cnt_nxt;
			stable_r <= stable_nxt;
			snap_r <= snap_nxt;
			cal_prev_r <= cal_prev_nxt;
			cal_start_r <= cal_start_nxt;
			irq_o_r <= irq_o_nxt;
			irq_oe_r <= irq_oe_nxt;
			host_rdata <= rdata_nxt;
			host_rvalid <= rvalid_nxt;
		end
	end

	assign strap_latched = strap_r;
	assign profile_load = boot_r == clock_cfg_pkg::BOOT_LATCH;
	assign device_in_reset = dev_rst;
	// Pin 4 only drives as SERIAL_DATA_OUT; in reset every strap pin is an input
	assign strap_pin_4_oe = !dev_rst && !strap_r.i2c_mode && shadow_r[`IX_SPCFG][`SPC_4WIRE_BIT]
		&& serial_data_out_en;
	assign strap_pin_4_o = serial_data_out_data;
	assign mpin4_free = strap_r.i2c_mode || !shadow_r[`IX_SPCFG][`SPC_4WIRE_BIT];
	assign mpin5_free = strap_r.i2c_mode || shadow_r[`IX_SPCFG][`SPC_2WIRE_BIT];
	assign irq_pin_o = irq_o_r;
	assign irq_pin_oe = irq_oe_r;
	assign wdog_pin_oe = active_r[`IX_MPIN][`MPIN_WDOG_OUT_BIT];
	assign wdog_pin_o = wdog_pin_oe && wd_pulse_r != 4'h0;
	assign system_clock_stable = stable_r;
	assign free_run = {active_r[`IX_LOOP1_FR][`FREERUN_BIT], active_r[`IX_LOOP0_FR][`FREERUN_BIT]};
	assign soft_sync = {active_r[`IX_PLL1_CAL][`SYNC_BIT], active_r[`IX_PLL0_CAL][`SYNC_BIT]};
	assign cal_start = cal_start_r;
	assign free_run_word_0 = {active_r[{2'h1, `FREERUN_OFS + 7'h03}][5:0], active_r[{2'h1, `FREERUN_OFS + 7'h02}],
		active_r[{2'h1, `FREERUN_OFS + 7'h01}], active_r[{2'h1, `FREERUN_OFS}]};
	assign free_run_word_1 = {active_r[{2'h2, `FREERUN_OFS + 7'h03}][5:0], active_r[{2'h2, `FREERUN_OFS + 7'h02}],
		active_r[{2'h2, `FREERUN_OFS + 7'h01}], active_r[{2'h2, `FREERUN_OFS}]};
	assign driver_enable_0 = active_r[{2'h1, `DRV_EN_OFS}];
	assign driver_enable_1 = active_r[{2'h2, `DRV_EN_OFS}];
	// Loop 1 stores C, D, A, B, so flip the upper select bit
	assign prof0 = 7'(`PROFILE_BASE + `PROFILE_SIZE * 7'(loop0_ref_sel));
	assign prof1 = 7'(`PROFILE_BASE + `PROFILE_SIZE * 7'(loop1_ref_sel ^ 2'h2));
	assign loop0_priority = active_r[{2'h1, prof0}];
	assign loop1_priority = active_r[{2'h2, prof1}];
	generate
		for (g = 0; g < 4; g++) begin : g_ref
			assign ref_settings_first[g] = active_r[{2'h0, 7'(`REF_STRIDE * g)}];
		end
	endgenerate
endmodule
`default_nettype wire

// file: logic/clock_cfg_map.svh
`ifndef CLOCK_CFG_MAP_SVH
`define CLOCK_CFG_MAP_SVH
`define ADDR_SERIAL_CFG 16'h0000
`define ADDR_UPDATE 16'h0005
`define ADDR_MPIN_CFG 16'h0100
`define ADDR_WDOG_LO 16'h0108
`define ADDR_WDOG_HI 16'h0109
`define ADDR_MASK_FIRST 16'h010A
`define ADDR_MASK_LAST 16'h0112
`define ADDR_STAB_LO 16'h0206
`define ADDR_STAB_HI 16'h0207
`define ADDR_CLR_COMMON 16'h0A05
`define ADDR_CLR_FIRST 16'h0A06
`define ADDR_CLR_LAST 16'h0A0E
`define ADDR_PLL0_CAL 16'h0A20
`define ADDR_LOOP0_FR 16'h0A22
`define ADDR_PLL1_CAL 16'h0A40
`define ADDR_LOOP1_FR 16'h0A42
`define ADDR_SYS_STATUS 16'h0D01
`define ADDR_MON_FIRST 16'h0D08
`define ADDR_MON_LAST 16'h0D10
`define REGION_REF 8'h03
`define REGION_LOOP1 8'h05
`define REF_STRIDE 7'h20
`define FREERUN_OFS 7'h00
`define DRV_EN_OFS 7'h28
`define PROFILE_BASE 7'h40
`define PROFILE_SIZE 7'h0D
`define IX_SPCFG 9'h180
`define IX_MPIN 9'h181
`define IX_WD_LO 9'h182
`define IX_WD_HI 9'h183
`define IX_MASK 9'h184
`define IX_STAB_LO 9'h18D
`define IX_STAB_HI 9'h18E
`define IX_PLL0_CAL 9'h18F
`define IX_LOOP0_FR 9'h190
`define IX_PLL1_CAL 9'h191
`define IX_LOOP1_FR 9'h192
`define IX_COUNT 403
`define GROUP_COUNT 9
`define UPDATE_CMD 8'h01
`define SPC_4WIRE_BIT 7
`define SPC_2WIRE_BIT 5
`define CLR_ALL_BIT 0
`define CLR_WDOG_BIT 7
`define FREERUN_BIT 0
`define CAL_BIT 1
`define SYNC_BIT 2
`define MPIN_SINGLE_IRQ_BIT 0
`define MPIN_PUSH_PULL_BIT 1
`define MPIN_WDOG_OUT_BIT 2
`define STAB_DEFAULT_MS 8'h32
`define CLK_PERIOD_NS 100
`define NS_PER_MS 1000000
`define WD_PULSE_NS 40
`define POR_MS 20
`endif

// file: logic/clock_cfg_pkg.sv
package clock_cfg_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef struct packed {
		logic [1:0] profile;
		logic i2c_mode;
		logic [1:0] i2c_addr;
	} strap_s;
	typedef enum logic [1:0] {
		BOOT_HOLD = 2'b00,
		BOOT_LATCH = 2'b01,
		BOOT_RUN = 2'b10
	} boot_state_e;
endpackage

// file: testbench/clock_cfg_props.sv
`timescale 1ns/1ns
`default_nettype none
module clock_cfg_props #(
	parameter int CYC_PER_MS = 4
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire clock_cfg_pkg::reg_req_s host_req,
	input wire logic host_rvalid,
	input wire logic strap_pin_4_oe,
	input wire logic mpin4_free,
	input wire clock_cfg_pkg::strap_s strap_latched,
	input wire logic profile_load,
	input wire logic device_in_reset,
	input wire logic [2:0] irq_pin_oe,
	input wire logic wdog_pin_o,
	input wire logic system_clock_pll_locked,
	input wire logic system_clock_stable,
	input wire logic [1:0] free_run,
	input wire logic [1:0] cal_start,
	input wire logic [29:0] free_run_word_0,
	input wire logic [7:0] driver_enable_0
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Slack of two cycles for where the lock count starts
	localparam int STAB_MIN = 50 * CYC_PER_MS - 2;
	logic [15:0] lock_cnt_r;
	logic [15:0] lock_cnt_nxt;
	logic upd_w;
	assign upd_w = host_req.wr && host_req.addr == 16'h0005 && host_req.wdata == 8'h01;
	// Saturates so a long lock cannot wrap to zero
	always_comb begin
		lock_cnt_nxt = system_clock_pll_locked ? lock_cnt_r + {15'h0000, ~&lock_cnt_r} : 16'h0000;
	end
	always_ff @(posedge core_clk) begin
		lock_cnt_r <= reset_n ? lock_cnt_nxt : 16'h0000;
	end
	chk_read_answer: assert property (host_req.rd && !device_in_reset |=> host_rvalid)
		else $error("read got no answer");
	chk_profile_pulse: assert property (profile_load |=> !profile_load)
		else $error("profile load longer than one cycle");
	chk_strap_hold: assert property (!profile_load && !device_in_reset |=> $stable(strap_latched))
		else $error("latched straps moved");
	chk_reset_quiet: assert property (device_in_reset ##1 device_in_reset |-> irq_pin_oe == 3'h0 && !strap_pin_4_oe)
		else $error("pin driven during reset");
	chk_sdo_pin: assert property (strap_pin_4_oe |-> !mpin4_free)
		else $error("pin 4 both free and driven");
	chk_cal_pulse: assert property (cal_start[0] |=> !cal_start[0])
		else $error("calibration start repeated");
	chk_wdog_pulse: assert property (wdog_pin_o |=> !wdog_pin_o)
		else $error("watchdog pulse too long");
	chk_stable_lock: assert property ($rose(system_clock_stable) |-> lock_cnt_r >= STAB_MIN)
		else $error("stable before lock time");
	chk_update_gate: assert property ($changed({free_run, free_run_word_0, driver_enable_0})
		|-> $past(upd_w) || $past(upd_w, 2))
		else $error("active setting moved without update");
	chk_drv_reset: assert property (device_in_reset |=> driver_enable_0 == 8'h00)
		else $error("driver enabled in reset");
	cover property (cal_start[0]);
	cover property (wdog_pin_o);
	cover property ($rose(system_clock_stable));
endmodule
bind clock_cfg_ctrl clock_cfg_props #(.CYC_PER_MS(CYC_PER_MS)) props (.core_clk, .reset_n, .host_req,
	.host_rvalid, .strap_pin_4_oe, .mpin4_free, .strap_latched, .profile_load, .device_in_reset,
	.irq_pin_oe, .wdog_pin_o, .system_clock_pll_locked, .system_clock_stable, .free_run, .cal_start,
	.free_run_word_0, .driver_enable_0);
`default_nettype wire

// file: testbench/host_model.sv
`timescale 1ns/1ns
`default_nettype none
// No chip select: this host owns the port alone
module host_model (
	input wire logic core_clk,
	output var clock_cfg_pkg::reg_req_s host_req,
	input wire logic [7:0] host_rdata,
	input wire logic host_rvalid
);
	initial host_req = '0;
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge core_clk);
		host_req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(negedge core_clk);
		host_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] v, output logic ok);
		@(negedge core_clk);
		host_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge core_clk);
		host_req.rd = 1'b0;
		ok = host_rvalid;
		v = host_rdata;
	endtask
	task automatic upd();
		wr(16'h0005, 8'h01);
		repeat (2) @(negedge core_clk);
	endtask
	// Loops parked first so half-written settings never steer them
	task automatic enter_free_run();
		wr(16'h0A22, 8'h01);
		wr(16'h0A42, 8'h01);
		upd();
	endtask
	task automatic leave_free_run();
		wr(16'h0A22, 8'h00);
		wr(16'h0A42, 8'h00);
		upd();
	endtask
	// Status is a snapshot, so refresh it before every look
	task automatic poll(output logic [7:0] v, output logic ok);
		upd();
		rd(16'h0D01, v, ok);
	endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic core_clk, reset_n, supply_ok, strap_pin_0, strap_pin_1, interface_select_strap, strap_pin_4;
	logic strap_pin_5, serial_data_out_data, serial_data_out_en, system_clock_pll_locked;
	logic [71:0] irq_event;
	logic [1:0] loop0_ref_sel, loop1_ref_sel, free_run, soft_sync, cal_start;
	clock_cfg_pkg::reg_req_s host_req;
	clock_cfg_pkg::strap_s strap_latched;
	logic [7:0] host_rdata, driver_enable_0, driver_enable_1, loop0_priority, loop1_priority, d;
	logic [7:0] ref_settings_first [4];
	logic host_rvalid, strap_pin_4_o, strap_pin_4_oe, mpin4_free, mpin5_free, profile_load, ok;
	logic device_in_reset, wdog_pin_o, wdog_pin_oe, system_clock_stable;
	logic [2:0] irq_pin_o, irq_pin_oe;
	logic [29:0] free_run_word_0, free_run_word_1;
	int fail_count = 0, tests_run = 0, cal_cnt = 0, wd_cnt = 0;
	clock_cfg_ctrl #(.POR_CYCLES(20), .CYC_PER_MS(4)) dut (.core_clk, .reset_n, .supply_ok, .host_req,
		.host_rdata, .host_rvalid, .strap_pin_0, .strap_pin_1, .interface_select_strap, .strap_pin_4,
		.strap_pin_5, .serial_data_out_data, .serial_data_out_en, .strap_pin_4_o, .strap_pin_4_oe,
		.mpin4_free, .mpin5_free, .strap_latched, .profile_load, .device_in_reset, .irq_event,
		.irq_pin_o, .irq_pin_oe, .wdog_pin_o, .wdog_pin_oe, .system_clock_pll_locked, .system_clock_stable,
		.free_run, .soft_sync, .cal_start, .free_run_word_0, .free_run_word_1, .driver_enable_0,
		.driver_enable_1, .loop0_ref_sel, .loop1_ref_sel, .loop0_priority, .loop1_priority,
		.ref_settings_first);
	host_model host (.core_clk, .host_req, .host_rdata, .host_rvalid);
	always #50 core_clk = ~core_clk;
	// Counted mid-cycle so a pulse is never read on the edge that moves it
	always @(negedge core_clk) begin
		if (cal_start[0] === 1'b1)
			cal_cnt++;
		if (wdog_pin_o === 1'b1)
			wd_cnt++;
	end
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e);
		host.rd(a, d, ok);
		chk(n, {1'b1, e}, {ok, d});
	endtask
	task automatic evt();
		@(negedge core_clk);
		irq_event[0] = 1'b1;
		@(negedge core_clk);
		irq_event[0] = 1'b0;
	endtask
	task automatic t_boot();
		int n;
		n = 0;
		while (device_in_reset !== 1'b0 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		chk("por_len", 1, n >= 18 && n <= 22);
		repeat (4) @(negedge core_clk);
		strap_pin_0 = 1'b0;
		@(negedge core_clk);
		chk("straps", 5'h0D, strap_latched);
		chk("mpin_free", 2'h3, {mpin4_free, mpin5_free});
		chk("sdo_oe_i2c", 0, strap_pin_4_oe);
		$display("boot test done");
	endtask
	task automatic t_update();
		host.enter_free_run();
		chk("free_run_on", 2'h3, free_run);
		for (int i = 0; i < 4; i++)
			host.wr(16'h0400 + 16'(i), 8'(32'h1234_5678 >> (8 * i)));
		for (int i = 0; i < 4; i++)
			host.wr(16'h0500 + 16'(i), 8'(32'h2A5A_C3E1 >> (8 * i)));
		host.wr(16'h0428, 8'h0F);
		host.wr(16'h0528, 8'hF0);
		host.wr(16'h0000, 8'h80);
		chk("word_held", 0, free_run_word_0);
		chk("word1_held", 0, free_run_word_1);
		chk("drv_off", 0, driver_enable_0);
		host.upd();
		chk("word", 30'h1234_5678, free_run_word_0);
		chk("drv_on", 8'h0F, driver_enable_0);
		chk("word1", 30'h2A5A_C3E1, free_run_word_1);
		chk("drv1_on", 8'hF0, driver_enable_1);
		chk("mpin4_i2c", 1, mpin4_free);
		rchk("update_reg", 16'h0005, 8'h00);
		$display("update test done");
	endtask
	task automatic t_cal();
		host.wr(16'h0A20, 8'h04);
		host.upd();
		chk("soft_sync", 2'h1, soft_sync);
		host.wr(16'h0A20, 8'h02);
		host.upd();
		chk("cal_once", 1, cal_cnt);
		host.upd();
		chk("cal_no_repeat", 1, cal_cnt);
		host.wr(16'h0A20, 8'h00);
		host.upd();
		host.wr(16'h0A20, 8'h02);
		host.upd();
		chk("cal_rearm", 2, cal_cnt);
		$display("calibration test done");
	endtask
	task automatic t_irq();
		evt();
		rchk("mon_unmasked", 16'h0D08, 8'h00);
		chk("irq_oe_off", 0, irq_pin_oe);
		host.wr(16'h010A, 8'h01);
		host.upd();
		evt();
		rchk("mon_set", 16'h0D08, 8'h01);
		chk("irq_open_drain", 1, irq_pin_oe[0]);
		chk("irq_drive_low", 0, irq_pin_o);
		host.wr(16'h0A06, 8'h01);
		rchk("mon_clr_one", 16'h0D08, 8'h00);
		evt();
		host.wr(16'h0A05, 8'h01);
		rchk("mon_clr_all", 16'h0D08, 8'h00);
		$display("irq test done");
	endtask
	task automatic t_wdog();
		chk("wd_off", 0, wd_cnt);
		host.wr(16'h0100, 8'h04);
		host.wr(16'h0108, 8'h01);
		host.upd();
		wd_cnt = 0;
		repeat (40) @(negedge core_clk);
		chk("wd_rate", 1, wd_cnt >= 8 && wd_cnt <= 10);
		chk("wd_pin_oe", 1, wdog_pin_oe);
		rchk("wd_irq", 16'h0D08, 8'h01);
		// Let a pulse from an expiry before the first restart die out
		host.wr(16'h0A05, 8'h80);
		@(negedge core_clk);
		wd_cnt = 0;
		repeat (9) host.wr(16'h0A05, 8'h80);
		chk("wd_restart", 0, wd_cnt);
		host.wr(16'h0108, 8'h00);
		host.upd();
		$display("watchdog test done");
	endtask
	task automatic t_stable();
		int n;
		system_clock_pll_locked = 1'b1;
		repeat (150) @(negedge core_clk);
		chk("stable_early", 0, system_clock_stable);
		n = 0;
		while (system_clock_stable !== 1'b1 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		chk("stable_late", 1, system_clock_stable);
		host.poll(d, ok);
		chk("status_stable", 2'h3, {ok, d[1]});
		$display("stability test done");
	endtask
	task automatic t_map();
		rchk("unmapped", 16'h0F00, 8'h00);
		host.wr(16'h044D, 8'h5A);
		host.wr(16'h0540, 8'hA5);
		host.wr(16'h0320, 8'h3C);
		host.upd();
		chk("prio0_refb", 8'h5A, loop0_priority);
		chk("prio1_refc", 8'hA5, loop1_priority);
		chk("ref_b_block", 8'h3C, ref_settings_first[1]);
		host.leave_free_run();
		chk("free_run_off", 0, free_run);
		$display("map test done");
	endtask
	// Second reset in mid-run with the select strap low
	task automatic t_spi();
		interface_select_strap = 1'b0;
		reset_n = 1'b0;
		repeat (4) @(negedge core_clk);
		chk("drv_reset", 0, {driver_enable_1, driver_enable_0});
		reset_n = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("strap_spi", 5'h01, strap_latched);
		chk("spi_pins", 2'h2, {mpin4_free, mpin5_free});
		host.wr(16'h0000, 8'h80);
		chk("sdo_drive", 2'h3, {strap_pin_4_oe, strap_pin_4_o});
		chk("sdo_pin_busy", 0, mpin4_free);
		host.wr(16'h0000, 8'h20);
		chk("two_wire", 2'h3, {mpin4_free, mpin5_free});
		chk("sdo_released", 0, strap_pin_4_oe);
		$display("spi test done");
	endtask
	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		supply_ok = 1'b0;
		{strap_pin_1, strap_pin_0, interface_select_strap, strap_pin_5, strap_pin_4} = 5'h0D;
		{serial_data_out_data, serial_data_out_en, system_clock_pll_locked} = 3'h6;
		irq_event = '0;
		loop0_ref_sel = 2'h1;
		loop1_ref_sel = 2'h2;
		repeat (4) @(negedge core_clk);
		chk("sdo_oe_reset", 0, strap_pin_4_oe);
		reset_n = 1'b1;
		supply_ok = 1'b1;
		t_boot();
		t_update();
		t_cal();
		t_irq();
		t_wdog();
		t_stable();
		t_map();
		t_spi();
		summarize();
	end
endmodule
`default_nettype wire
